//--- keyscan_pkg.sv
package keyscan_pkg;

  localparam int         DATA_W         = 8;
  localparam int         DIGITS         = 8;
  localparam logic [7:0] SELECT_ALL_ONES = 8'hFF;
  localparam logic [7:0] SELECT_FIRST    = 8'hFE;
  localparam logic [7:0] NIBBLE_MASK     = 8'h0F;
  localparam logic [2:0] PTR_FIRST       = 3'h0;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam int         SELECT_DONE_BIT = 1;
  localparam int         DWELL_DEFAULT   = 100;
  localparam int         SETTLE_CYCLES   = 2;
  localparam logic [7:0] DWELL_RESET     = 8'h64;

  typedef enum logic [3:0] {
    ST_REFRESH_INIT,
    ST_SHOW_DIGIT,
    ST_DWELL,
    ST_KEY_INIT,
    ST_COL_STEP,
    ST_COL_SAMPLE,
    ST_PAIR_DONE
  } scan_state_t;

endpackage

//--- dwell_timer.sv
`timescale 1ns/1ns
module dwell_timer
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [7:0] loadValue,
  output logic            expired
);
  logic [7:0] count_reg;

  // down counter; expires when it reaches one
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      count_reg <= 8'h00;
    else if (load)
      count_reg <= loadValue;
    else if (count_reg != 8'h00)
      count_reg <= count_reg - 8'h01;
  end

  assign expired = (count_reg <= 8'h01) && !load;
endmodule // dwell_timer

//--- key_matrix_display_scanner.sv
`timescale 1ns/1ns
// What this block does
// [RULE1] blank segments during key scan, then resume refresh
// [RULE2] key scan loads select all ones, zero in
// [RULE3] each column step rotates select left, carry in
// [RULE4] drive select, then sample four key returns
// [RULE5] pressed key pulls low, stored inverted as one
// [RULE6] keep lower nibble, upper four bits zero
// [RULE7] swap nibbles between first and second column
// [RULE8] equal to previous sample: write stable register
// [RULE9] differing sample: update debounce, keep key register
// [RULE10] first pair to set a, last pair b
// [RULE11] select bit 1 high marks second pair done
// [RULE12] refresh starts select FE, pointer first digit
// [RULE13] patterns loaded externally into eight locations
// [RULE14] drive segment pattern first, then digit select
// [RULE15] after dwell rotate left with one, increment pointer
// [RULE16] pointer wrapping to zero ends refresh cycle
// [RULE17] programmable dwell count reloaded per digit
// [RULE18] pick dwell for 250 to 500 Hz refresh
// [RULE19] blank: all high common anode, zero cathode
// [RULE20] invert segments common anode, pass cathode
// [RULE21] keys 1-8 in a, 9-16 in b
module key_matrix_display_scanner
  import keyscan_pkg::*;
#(
  parameter logic [7:0] DWELL_COUNT = 8'(DWELL_DEFAULT)
)
(
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                commonAnode,
  input  wire logic                keyScanRequest,
  input  wire logic [3:0]          keyReturn,
  input  wire logic [7:0]          dwellCount,
  input  wire logic                digitWriteEn,
  input  wire logic [2:0]          digitWriteAddr,
  input  wire logic [keyscan_pkg::DATA_W-1:0] digitWriteData,
  output logic      [7:0]          digitSelectPort,
  output logic      [7:0]          segmentPort,
  output logic      [7:0]          stableKeysA,
  output logic      [7:0]          stableKeysB,
  output logic      [7:0]          debounceRegA,
  output logic      [7:0]          debounceRegB,
  output logic                     keyScanBusy,
  output logic                     refreshDone
);
  import keyscan_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // storage and helpers

  logic [DATA_W-1:0] digitMem [DIGITS];
  scan_state_t       state_reg;
  logic [7:0]        select_reg;
  logic              carry_reg;
  logic [2:0]        pointer_reg;
  logic [7:0]        work_reg;
  logic              colHalf_reg;
  logic              pendingScan_reg;
  logic [1:0]        settle_reg;
  logic              dwellLoad;
  logic              dwellExpired;
  logic [7:0]        dwellValue;

  function automatic logic [7:0] rotate_left(input logic [7:0] v, input logic cin);
    rotate_left = {v[6:0], cin};
  endfunction

  function automatic logic [7:0] blank_value(input logic anode);
    blank_value = anode ? 8'hFF : 8'h00;
  endfunction

  assign dwellValue = (dwellCount != 8'h00) ? dwellCount : DWELL_COUNT; // see [RULE17] see [RULE18]
  assign dwellLoad  = (state_reg == ST_SHOW_DIGIT);

  dwell_timer u_dwell
  (
    .core_clk  (core_clk),
    .rst       (rst),
    .load      (dwellLoad),
    .loadValue (dwellValue),
    .expired   (dwellExpired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // digit pattern store, filled by the outside source

  always_ff @(posedge core_clk)
  begin
    if (digitWriteEn)
      digitMem[digitWriteAddr] <= digitWriteData; // see [RULE13]
  end

  ////////////////////////////////////////////////////////////////////////////
  // key scan request latch

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pendingScan_reg <= 1'b0;
    else if (keyScanRequest)
      pendingScan_reg <= 1'b1;
    else if (state_reg == ST_KEY_INIT)
      pendingScan_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg   <= ST_REFRESH_INIT;
      select_reg  <= SELECT_ALL_ONES;
      carry_reg   <= 1'b0;
      pointer_reg <= PTR_FIRST;
      work_reg    <= RESET_BYTE;
      colHalf_reg <= 1'b0;
      settle_reg  <= 2'h0;
    end
    else
    begin
      case (state_reg)
        ST_REFRESH_INIT:
        begin
          if (pendingScan_reg)
            state_reg <= ST_KEY_INIT;
          else
          begin
            select_reg  <= SELECT_FIRST; // see [RULE12]
            pointer_reg <= PTR_FIRST;    // see [RULE12]
            state_reg   <= ST_SHOW_DIGIT;
          end
        end
        ST_SHOW_DIGIT:
          state_reg <= ST_DWELL;
        ST_DWELL:
        begin
          if (dwellExpired)
          begin
            select_reg  <= rotate_left(select_reg, 1'b1); // see [RULE15]
            pointer_reg <= pointer_reg + 3'h1;            // see [RULE15]
            if (pointer_reg == 3'h7)                      // see [RULE16]
              state_reg <= ST_REFRESH_INIT;
            else
              state_reg <= ST_SHOW_DIGIT;
          end
        end
        ST_KEY_INIT:
        begin
          select_reg  <= SELECT_ALL_ONES; // see [RULE2]
          carry_reg   <= 1'b0;            // see [RULE2]
          work_reg    <= RESET_BYTE;
          colHalf_reg <= 1'b0;
          state_reg   <= ST_COL_STEP;
        end
        ST_COL_STEP:
        begin
          select_reg <= rotate_left(select_reg, carry_reg); // see [RULE3]
          carry_reg  <= select_reg[7];
          settle_reg <= 2'(SETTLE_CYCLES);
          state_reg  <= ST_COL_SAMPLE;
        end
        ST_COL_SAMPLE:
        begin
          if (settle_reg != 2'h0)
            settle_reg <= settle_reg - 2'h1;
          else if (!colHalf_reg)
          begin
            // see [RULE4] see [RULE5] see [RULE6] see [RULE7]
            work_reg    <= {~keyReturn, 4'h0};
            colHalf_reg <= 1'b1;
            state_reg   <= ST_COL_STEP;
          end
          else
          begin
            work_reg    <= work_reg | ({4'h0, ~keyReturn} & NIBBLE_MASK); // see [RULE6]
            colHalf_reg <= 1'b0;
            state_reg   <= ST_PAIR_DONE;
          end
        end
        ST_PAIR_DONE:
        begin
          work_reg <= RESET_BYTE;
          if (select_reg[SELECT_DONE_BIT]) // see [RULE11]
            state_reg <= ST_REFRESH_INIT;  // see [RULE1]
          else
            state_reg <= ST_COL_STEP;
        end
        default:
          state_reg <= ST_REFRESH_INIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // debounce and stable key registers

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      debounceRegA <= RESET_BYTE;
      debounceRegB <= RESET_BYTE;
      stableKeysA  <= RESET_BYTE;
      stableKeysB  <= RESET_BYTE;
    end
    else if (state_reg == ST_PAIR_DONE)
    begin
      if (!select_reg[SELECT_DONE_BIT]) // see [RULE10] see [RULE21]
      begin
        if ((work_reg ^ debounceRegA) == 8'h00)
          stableKeysA <= work_reg; // see [RULE8]
        debounceRegA <= work_reg;  // see [RULE9]
      end
      else
      begin
        if ((work_reg ^ debounceRegB) == 8'h00)
          stableKeysB <= work_reg; // see [RULE8]
        debounceRegB <= work_reg;  // see [RULE9]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output ports

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      segmentPort     <= 8'h00;
      digitSelectPort <= 8'hFF;
      keyScanBusy     <= 1'b0;
      refreshDone     <= 1'b0;
    end
    else
    begin
      keyScanBusy <= (state_reg == ST_KEY_INIT) || (state_reg == ST_COL_STEP)
                     || (state_reg == ST_COL_SAMPLE) || (state_reg == ST_PAIR_DONE);
      refreshDone <= (state_reg == ST_DWELL) && dwellExpired && (pointer_reg == 3'h7); // see [RULE16]
      case (state_reg)
        ST_KEY_INIT:
          segmentPort <= blank_value(commonAnode); // see [RULE1] see [RULE19]
        ST_SHOW_DIGIT:
          segmentPort <= commonAnode ? ~digitMem[pointer_reg] : digitMem[pointer_reg]; // see [RULE14] see [RULE20]
        default:
          segmentPort <= segmentPort;
      endcase
      case (state_reg)
        ST_DWELL:
          digitSelectPort <= select_reg; // see [RULE14]
        ST_COL_SAMPLE:
          digitSelectPort <= select_reg; // see [RULE4]
        ST_SHOW_DIGIT, ST_REFRESH_INIT:
          digitSelectPort <= 8'hFF;
        default:
          digitSelectPort <= digitSelectPort;
      endcase
    end
  end

endmodule // key_matrix_display_scanner

//--- key_matrix_display_scanner_asserts.sv
`timescale 1ns/1ns
module key_scan_checker
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       commonAnode,
  input wire logic [7:0] digitSelectPort,
  input wire logic [7:0] segmentPort,
  input wire logic [7:0] stableKeysA,
  input wire logic [7:0] stableKeysB,
  input wire logic [7:0] debounceRegA,
  input wire logic       keyScanBusy,
  input wire logic       refreshDone
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_blank_in_scan: assert property (keyScanBusy && digitSelectPort != 8'hFF |->
    segmentPort == (commonAnode ? 8'hFF : 8'h00)) else $error("segments not blank in scan");
  a_single_low: assert property (digitSelectPort != 8'hFF |-> $onehot(~digitSelectPort))
    else $error("select not one low");
  a_keys_idle: assert property (!keyScanBusy && !$past(keyScanBusy) |->
    $stable(stableKeysA) && $stable(stableKeysB)) else $error("keys moved outside scan");
  a_key_equals_deb: assert property ($changed(stableKeysA) |-> stableKeysA == debounceRegA)
    else $error("key write without equal sample");
  a_done_pulse: assert property (refreshDone |=> !refreshDone) else $error("done too long");
  a_select_rotate: assert property ($changed(digitSelectPort) && digitSelectPort != 8'hFF &&
    digitSelectPort != 8'hFE && $past(digitSelectPort) != 8'hFF |->
    digitSelectPort == (($past(digitSelectPort) << 1) | 8'h01)) else $error("select not rotated");
  a_segment_first: assert property (!keyScanBusy && $changed(digitSelectPort) &&
    digitSelectPort != 8'hFF |-> $stable(segmentPort)) else $error("segments moved with select");
  a_deb_in_scan: assert property (!$past(rst) && $changed(debounceRegA) |->
    keyScanBusy || $past(keyScanBusy)) else $error("debounce moved outside scan");
endmodule // key_scan_checker

bind key_matrix_display_scanner key_scan_checker i_chk (.core_clk(core_clk), .rst(rst),
  .commonAnode(commonAnode), .digitSelectPort(digitSelectPort), .segmentPort(segmentPort),
  .stableKeysA(stableKeysA), .stableKeysB(stableKeysB), .debounceRegA(debounceRegA),
  .keyScanBusy(keyScanBusy), .refreshDone(refreshDone));

//--- key_matrix_model.sv
`timescale 1ns/1ns
module key_matrix_model
(
  input  wire logic [7:0]  digitSelectPort,
  input  wire logic [15:0] pressed,
  output logic      [3:0]  keyReturn
);
  // closed key pulls low, pull-ups hold idle returns high
  always_comb
  begin
    case (digitSelectPort)
      8'hFE:   keyReturn = ~pressed[7:4];
      8'hFD:   keyReturn = ~pressed[3:0];
      8'hFB:   keyReturn = ~pressed[15:12];
      8'hF7:   keyReturn = ~pressed[11:8];
      default: keyReturn = 4'hF;
    endcase
  end
endmodule // key_matrix_model

//--- tb.sv
`timescale 1ns/1ns
module tb;
  import keyscan_pkg::*;
  logic        core_clk, rst, commonAnode, keyScanRequest, digitWriteEn, keyScanBusy, refreshDone;
  logic [3:0]  keyReturn;
  logic [2:0]  digitWriteAddr;
  logic [7:0]  dwellCount, digitWriteData, digitSelectPort, segmentPort;
  logic [7:0]  stableKeysA, stableKeysB, debounceRegA, debounceRegB;
  logic [15:0] pressed;
  int          fail_count, cmp_count;
  key_matrix_display_scanner #(.DWELL_COUNT(8'h03)) i_key_matrix_display_scanner (.core_clk(core_clk),
    .rst(rst), .commonAnode(commonAnode), .keyScanRequest(keyScanRequest), .keyReturn(keyReturn),
    .dwellCount(dwellCount), .digitWriteEn(digitWriteEn), .digitWriteAddr(digitWriteAddr),
    .digitWriteData(digitWriteData), .digitSelectPort(digitSelectPort), .segmentPort(segmentPort),
    .stableKeysA(stableKeysA), .stableKeysB(stableKeysB), .debounceRegA(debounceRegA),
    .debounceRegB(debounceRegB), .keyScanBusy(keyScanBusy), .refreshDone(refreshDone));
  key_matrix_model i_key_matrix_model (.digitSelectPort(digitSelectPort), .pressed(pressed),
    .keyReturn(keyReturn));
  ////////////////////////////////////////
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_sel(logic [7:0] v);
    int n;
    n = 0;
    while (digitSelectPort !== v && n < 300)
    begin
      @(negedge core_clk);
      n++;
    end
    check("select", v, digitSelectPort);
  endtask
  task automatic scan();
    int n;
    n = 0;
    keyScanRequest = 1'b1;
    @(negedge core_clk);
    keyScanRequest = 1'b0;
    while (keyScanBusy !== 1'b1 && n < 500)
    begin
      @(negedge core_clk);
      n++;
    end
    while (keyScanBusy !== 1'b0 && n < 1000)
    begin
      @(negedge core_clk);
      n++;
    end
    check("scan end", 8'h00, {7'h00, keyScanBusy});
  endtask
  ////////////////////////////////////////
  task automatic t_refresh(logic anode);
    logic [7:0] s, p;
    commonAnode = anode;
    s = SELECT_FIRST;
    for (int i = 0; i < DIGITS; i++)
    begin
      p = 8'(8'h13 * (i + 1));
      wait_sel(s);
      check("segments", anode ? ~p : p, segmentPort);
      s = {s[6:0], 1'b1};
    end
    for (int i = 0; i < 100 && refreshDone !== 1'b1; i++)
      @(negedge core_clk);
    check("refresh done", 8'h01, {7'h00, refreshDone});
    $display("test refresh anode=%0d done", anode);
  endtask
  task automatic t_keys(logic [15:0] k, logic [15:0] keep);
    pressed = k;
    scan();
    check("debounce a", k[7:0], debounceRegA);
    check("debounce b", k[15:8], debounceRegB);
    check("held a", keep[7:0], stableKeysA);
    check("held b", keep[15:8], stableKeysB);
    scan();
    check("keys a", k[7:0], stableKeysA);
    check("keys b", k[15:8], stableKeysB);
    $display("test keys %h done", k);
  endtask
  ////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
  initial
  begin
    rst = 1'b1;
    commonAnode = 1'b1;
    keyScanRequest = 1'b0;
    dwellCount = 8'h02;
    digitWriteEn = 1'b0;
    digitWriteAddr = 3'h0;
    digitWriteData = 8'h00;
    pressed = 16'h0000;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    check("reset keys", 8'h00, stableKeysA);
    digitWriteEn = 1'b1;
    for (int i = 0; i < DIGITS; i++)
    begin
      digitWriteAddr = 3'(i);
      digitWriteData = 8'(8'h13 * (i + 1));
      @(negedge core_clk);
    end
    digitWriteEn = 1'b0;
    t_refresh(1'b1);
    scan();
    t_keys(16'h8421, 16'h0000);
    t_keys(16'h1E78, 16'h8421);
    dwellCount = 8'h00;
    t_refresh(1'b0);
    t_keys(16'hFFFF, 16'h1E78);
    t_refresh(1'b0);
    tally_and_finish();
  end
endmodule // tb
